/* core/tlu_defs.vh */
`ifndef TLU_DEFS_VH
`define TLU_DEFS_VH
`define TLU_DENT     128
`define TLU_IENT     8
`define TLU_OFS_PCTX0 8'h00
`define TLU_OFS_PCTX1 8'h04
`define TLU_OFS_SCTX0 8'h08
`define TLU_OFS_SCTX1 8'h0c
`define TLU_OFS_TCFG  8'h10
`define TLU_OFS_DINHI 8'h14
`define TLU_OFS_DINLO 8'h18
`define TLU_OFS_LOAD  8'h1c
`define TLU_OFS_DEMAP 8'h20
`define TLU_OFS_STAT  8'h24
`define TLU_OFS_MASK  8'h28
`define TLU_OFS_FVA   8'h2c
`define TLU_SZ_8K    3'h0
`define TLU_SZ_64K   3'h1
`define TLU_SZ_4M    3'h3
`define TLU_SZ_256M  3'h5
`define TLU_MSK_8K   19'h7ffff
`define TLU_MSK_64K  19'h7fff8
`define TLU_MSK_4M   19'h7fe00
`define TLU_MSK_256M 19'h78000
`define TLU_TTE_V    63
`define TLU_TTE_R    62
`define TLU_TTE_SZ   61:59
`define TLU_TTE_CTX  58:51
`define TLU_TTE_VPN  50:32
`define TLU_TTE_PPN  31:13
`define TLU_TTE_W    1
`define TLU_ST_IMULTI 0
`define TLU_ST_DMULTI 1
`define TLU_ST_SIZE   2
`define TLU_ST_WALK   3
`define TLU_TCFG_RST  32'h00000000
`endif

/* core/translation_lookaside_unit.v */
// Summary of operation
// - data buffer holds 128 page mappings, searched on each data access.
// - two primary and two secondary context registers select the match context.
// - no lock flag; any entry may be replaced or demapped.
// - data-in and loads use one single entry layout only.
// - hardware walker fetches missing mappings from memory tables.
// - table base is a physical address, used untranslated.
// - four page sizes 8K, 64K, 4M, 256M, offset mask chosen per entry.
// - illegal size in table config or entry load raises size trap.
// - demap-real invalidates every entry with real flag set.
// - autodemap removes overlapping entries of equal or larger size only.
// - more than one hit reports a multiple-hit error.
// - faults are reported as distinct data and fetch fault variants.
`include "tlu_defs.vh"
module translation_lookaside_unit (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata_ff,
  output reg         irq_ff,
  input  wire        iReq,
  input  wire [31:0] iVa,
  input  wire [1:0]  iCtxSel,
  input  wire        iReal,
  output reg         iAck_ff,
  output reg  [31:0] iPa_ff,
  output reg  [1:0]  fetchFaultVariants_ff,
  input  wire        dReq,
  input  wire [31:0] dVa,
  input  wire [1:0]  dCtxSel,
  input  wire        dReal,
  input  wire        dWrite,
  output reg         dAck_ff,
  output reg  [31:0] dPa_ff,
  output reg  [2:0]  dataFaultVariants_ff,
  output reg         memReq_ff,
  output reg  [31:0] memAddr_ff,
  input  wire        memAck,
  input  wire [63:0] memRdata
);
  localparam IDLE = 4'h1;
  localparam LOOK = 4'h2;
  localparam WALK = 4'h4;
  localparam FILL = 4'h8;

  function [18:0] vmask;
    input [2:0] s;
    begin
      case (s)
        `TLU_SZ_64K:  vmask = `TLU_MSK_64K;
        `TLU_SZ_4M:   vmask = `TLU_MSK_4M;
        `TLU_SZ_256M: vmask = `TLU_MSK_256M;
        default:      vmask = `TLU_MSK_8K;
      endcase
    end
  endfunction

  function legal;
    input [2:0] s;
    begin
      legal = (s == `TLU_SZ_8K) || (s == `TLU_SZ_64K) ||
              (s == `TLU_SZ_4M) || (s == `TLU_SZ_256M);
    end
  endfunction

  reg [63:0] dTte [0:`TLU_DENT-1];
  reg [63:0] iTte [0:`TLU_IENT-1];
  reg [7:0]  ctx_ff [0:3];
  reg [31:0] tcfg_ff;
  reg [31:0] dinHi_ff;
  reg [31:0] dinLo_ff;
  reg [3:0]  stat_ff;
  reg [3:0]  mask_ff;
  reg [31:0] fva_ff;
  reg [3:0]  state_ff;
  reg        side_ff;
  reg [31:0] va_ff;
  reg [7:0]  rctx_ff;
  reg        real_ff;
  reg        wr_ff;
  reg [63:0] walk_ff;
  reg [6:0]  dRepl_ff;
  reg [2:0]  iRepl_ff;

  wire [18:0] reqVpn = va_ff[31:13];
  wire        regLoad = regWr && (regAddr == `TLU_OFS_LOAD);
  wire        loadOk = legal(dinHi_ff[29:27]);
  wire        fillEn = (state_ff == FILL) || (regLoad && loadOk);
  wire [63:0] newTte = (state_ff == FILL) ? walk_ff : {dinHi_ff, dinLo_ff};
  wire        newSide = (state_ff == FILL) ? side_ff : regWdata[0];
  wire        dmReal = regWr && (regAddr == `TLU_OFS_DEMAP) && regWdata[0];
  wire        dmAll = regWr && (regAddr == `TLU_OFS_DEMAP) && regWdata[1];

  wire [`TLU_DENT-1:0] dHit;
  wire [`TLU_DENT-1:0] dKill;
  wire [`TLU_IENT-1:0] iHit;
  wire [`TLU_IENT-1:0] iKill;

  genvar k;
  generate
    for (k = 0; k < `TLU_DENT; k = k + 1) begin : g_ent
      wire [63:0] e = dTte[k];
      // real entries answer only real requests, context ignored for them
      assign dHit[k] = e[`TLU_TTE_V] && (e[`TLU_TTE_R] == real_ff) &&
                       (e[`TLU_TTE_R] || e[`TLU_TTE_CTX] == rctx_ff) &&
                       (((e[`TLU_TTE_VPN] ^ reqVpn) & vmask(e[`TLU_TTE_SZ])) == 19'h0);
      // sizes are coded in ascending order, so a numeric compare orders them
      assign dKill[k] = dmAll || (dmReal && e[`TLU_TTE_R]) ||
                        (fillEn && !newSide && e[`TLU_TTE_V] &&
                         e[`TLU_TTE_R] == newTte[`TLU_TTE_R] &&
                         (e[`TLU_TTE_R] || e[`TLU_TTE_CTX] == newTte[`TLU_TTE_CTX]) &&
                         e[`TLU_TTE_SZ] >= newTte[`TLU_TTE_SZ] &&
                         (((e[`TLU_TTE_VPN] ^ newTte[`TLU_TTE_VPN]) &
                           vmask(e[`TLU_TTE_SZ])) == 19'h0));
      if (k < `TLU_IENT) begin : g_i
        wire [63:0] f = iTte[k];
        assign iHit[k] = f[`TLU_TTE_V] && (f[`TLU_TTE_R] == real_ff) &&
                         (f[`TLU_TTE_R] || f[`TLU_TTE_CTX] == rctx_ff) &&
                         (((f[`TLU_TTE_VPN] ^ reqVpn) & vmask(f[`TLU_TTE_SZ])) == 19'h0);
        assign iKill[k] = dmAll || (dmReal && f[`TLU_TTE_R]) ||
                          (fillEn && newSide && f[`TLU_TTE_V] &&
                           f[`TLU_TTE_R] == newTte[`TLU_TTE_R] &&
                           (f[`TLU_TTE_R] || f[`TLU_TTE_CTX] == newTte[`TLU_TTE_CTX]) &&
                           f[`TLU_TTE_SZ] >= newTte[`TLU_TTE_SZ] &&
                           (((f[`TLU_TTE_VPN] ^ newTte[`TLU_TTE_VPN]) &
                             vmask(f[`TLU_TTE_SZ])) == 19'h0));
      end
    end
  endgenerate

  reg [`TLU_DENT-1:0] hitVec;
  reg [63:0]          hitTte;
  integer j;
  always @* begin
    hitVec = side_ff ? {{(`TLU_DENT-`TLU_IENT){1'b0}}, iHit} : dHit;
    hitTte = 64'h0;
    for (j = 0; j < `TLU_DENT; j = j + 1) begin
      if (hitVec[j]) begin
        hitTte = hitTte | (side_ff ? iTte[j % `TLU_IENT] : dTte[j]);
      end
    end
  end

  wire        multiHit = |(hitVec & (hitVec - 1'b1));
  wire        anyHit = |hitVec;
  wire [18:0] hm = vmask(hitTte[`TLU_TTE_SZ]);
  wire [31:0] hitPa = {(hitTte[`TLU_TTE_PPN] & hm) | (reqVpn & ~hm), va_ff[12:0]};
  wire        protErr = !side_ff && wr_ff && !hitTte[`TLU_TTE_W];
  wire        walkMatch = memRdata[`TLU_TTE_V] && (memRdata[`TLU_TTE_R] == real_ff) &&
                          (memRdata[`TLU_TTE_R] || memRdata[`TLU_TTE_CTX] == rctx_ff) &&
                          (((memRdata[`TLU_TTE_VPN] ^ reqVpn) &
                            vmask(memRdata[`TLU_TTE_SZ])) == 19'h0);
  wire        walkSizeBad = !legal(memRdata[`TLU_TTE_SZ]);

  reg [3:0] nxt_state;
  always @* begin
    case (state_ff)
      IDLE:    nxt_state = (iReq || dReq) ? LOOK : IDLE;
      LOOK:    nxt_state = anyHit ? IDLE : WALK;
      WALK:    nxt_state = !memAck ? WALK : (walkMatch && !walkSizeBad) ? FILL : IDLE;
      FILL:    nxt_state = LOOK;
      default: nxt_state = IDLE;
    endcase
  end

  reg [3:0] evt;
  always @* begin
    evt = 4'h0;
    evt[`TLU_ST_IMULTI] = (state_ff == LOOK) && side_ff && multiHit;
    evt[`TLU_ST_DMULTI] = (state_ff == LOOK) && !side_ff && multiHit;
    evt[`TLU_ST_SIZE] = (regLoad && !loadOk) ||
                        (regWr && regAddr == `TLU_OFS_TCFG && !legal(regWdata[2:0])) ||
                        ((state_ff == WALK) && memAck && walkMatch && walkSizeBad);
    evt[`TLU_ST_WALK] = (state_ff == WALK) && memAck && !walkMatch;
  end

  always @(posedge clk) begin
    if (rst) begin
      state_ff <= IDLE;
      side_ff <= 1'b0;
      va_ff <= 32'h0;
      rctx_ff <= 8'h0;
      real_ff <= 1'b0;
      wr_ff <= 1'b0;
      walk_ff <= 64'h0;
      iAck_ff <= 1'b0;
      dAck_ff <= 1'b0;
      iPa_ff <= 32'h0;
      dPa_ff <= 32'h0;
      fetchFaultVariants_ff <= 2'h0;
      dataFaultVariants_ff <= 3'h0;
      memReq_ff <= 1'b0;
      memAddr_ff <= 32'h0;
      fva_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      iAck_ff <= 1'b0;
      dAck_ff <= 1'b0;
      fetchFaultVariants_ff <= 2'h0;
      dataFaultVariants_ff <= 3'h0;
      iPa_ff <= 32'h0;
      dPa_ff <= 32'h0;
      case (state_ff)
        IDLE: begin
          // fetch wins when both arrive; the loser holds its request
          if (iReq || dReq) begin
            side_ff <= iReq;
            va_ff <= iReq ? iVa : dVa;
            rctx_ff <= ctx_ff[iReq ? iCtxSel : dCtxSel];
            real_ff <= iReq ? iReal : dReal;
            wr_ff <= !iReq && dWrite;
          end
        end
        LOOK: begin
          if (anyHit) begin
            iAck_ff <= side_ff;
            dAck_ff <= !side_ff;
            iPa_ff <= (side_ff && !multiHit) ? hitPa : 32'h0;
            dPa_ff <= (!side_ff && !multiHit && !protErr) ? hitPa : 32'h0;
            fetchFaultVariants_ff <= side_ff ? {multiHit, 1'b0} : 2'h0;
            dataFaultVariants_ff <= side_ff ? 3'h0 : {multiHit, !multiHit && protErr, 1'b0};
            if (multiHit || protErr) begin
              fva_ff <= va_ff;
            end
          end else begin
            memReq_ff <= 1'b1;
            memAddr_ff <= {tcfg_ff[31:12], reqVpn[8:0], 3'h0};
          end
        end
        WALK: begin
          if (memAck) begin
            memReq_ff <= 1'b0;
            walk_ff <= memRdata;
            if (!walkMatch || walkSizeBad) begin
              iAck_ff <= side_ff;
              dAck_ff <= !side_ff;
              fetchFaultVariants_ff <= side_ff ? 2'h1 : 2'h0;
              dataFaultVariants_ff <= side_ff ? 3'h0 : 3'h1;
              fva_ff <= va_ff;
            end
          end
        end
        default: ;
      endcase
    end
  end

  integer m, c;
  always @(posedge clk) begin
    if (rst) begin
      for (m = 0; m < `TLU_DENT; m = m + 1) begin
        dTte[m] <= 64'h0;
      end
      for (m = 0; m < `TLU_IENT; m = m + 1) begin
        iTte[m] <= 64'h0;
      end
      dRepl_ff <= 7'h0;
      iRepl_ff <= 3'h0;
    end else begin
      for (m = 0; m < `TLU_DENT; m = m + 1) begin
        if (dKill[m]) begin
          dTte[m][`TLU_TTE_V] <= 1'b0;
        end
      end
      for (m = 0; m < `TLU_IENT; m = m + 1) begin
        if (iKill[m]) begin
          iTte[m][`TLU_TTE_V] <= 1'b0;
        end
      end
      // plain round robin: with no lock flag every slot is a victim
      if (fillEn && !newSide) begin
        dTte[dRepl_ff] <= newTte;
        dRepl_ff <= dRepl_ff + 7'h1;
      end
      if (fillEn && newSide) begin
        iTte[iRepl_ff] <= newTte;
        iRepl_ff <= iRepl_ff + 3'h1;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      for (c = 0; c < 4; c = c + 1) begin
        ctx_ff[c] <= 8'h0;
      end
      tcfg_ff <= `TLU_TCFG_RST;
      dinHi_ff <= 32'h0;
      dinLo_ff <= 32'h0;
      stat_ff <= 4'h0;
      mask_ff <= 4'h0;
      regRdata_ff <= 32'h0;
      irq_ff <= 1'b0;
    end else begin
      if (regWr) begin
        case (regAddr)
          `TLU_OFS_PCTX0: ctx_ff[0] <= regWdata[7:0];
          `TLU_OFS_PCTX1: ctx_ff[1] <= regWdata[7:0];
          `TLU_OFS_SCTX0: ctx_ff[2] <= regWdata[7:0];
          `TLU_OFS_SCTX1: ctx_ff[3] <= regWdata[7:0];
          `TLU_OFS_TCFG: begin
            if (legal(regWdata[2:0])) begin
              tcfg_ff <= regWdata;
            end
          end
          `TLU_OFS_DINHI: dinHi_ff <= regWdata;
          `TLU_OFS_DINLO: dinLo_ff <= regWdata;
          `TLU_OFS_MASK:  mask_ff <= regWdata[3:0];
          default: ;
        endcase
      end
      // a new event in the clearing cycle survives the write-one-to-clear
      stat_ff <= (stat_ff & ~((regWr && regAddr == `TLU_OFS_STAT) ? regWdata[3:0] : 4'h0))
                 | evt;
      irq_ff <= |(stat_ff & mask_ff);
      regRdata_ff <= 32'h0;
      if (regRd) begin
        case (regAddr)
          `TLU_OFS_PCTX0: regRdata_ff <= {24'h0, ctx_ff[0]};
          `TLU_OFS_PCTX1: regRdata_ff <= {24'h0, ctx_ff[1]};
          `TLU_OFS_SCTX0: regRdata_ff <= {24'h0, ctx_ff[2]};
          `TLU_OFS_SCTX1: regRdata_ff <= {24'h0, ctx_ff[3]};
          `TLU_OFS_TCFG:  regRdata_ff <= tcfg_ff;
          `TLU_OFS_DINHI: regRdata_ff <= dinHi_ff;
          `TLU_OFS_DINLO: regRdata_ff <= dinLo_ff;
          `TLU_OFS_STAT:  regRdata_ff <= {28'h0, stat_ff};
          `TLU_OFS_MASK:  regRdata_ff <= {28'h0, mask_ff};
          `TLU_OFS_FVA:   regRdata_ff <= fva_ff;
          default:        regRdata_ff <= 32'h0;
        endcase
      end
    end
  end
endmodule // translation_lookaside_unit

/* verif/walk_memory.sv */
module walk_memory (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  input  wire logic [3:0]  delay,
  output logic             memAck,
  output logic [63:0]      memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] tbl [0:511];
  logic [3:0]  waitCnt;
  initial for (int i = 0; i < 512; i++) tbl[i] = 64'h0;
  always @(posedge clk) begin
    if (rst) begin
      memAck   <= 1'h0;
      memRdata <= 64'h0;
      waitCnt  <= 4'h0;
    end else if (memReq && !memAck && waitCnt == delay) begin
      memAck   <= 1'h1;
      memRdata <= tbl[memAddr[11:3]];
      waitCnt  <= 4'h0;
    end else begin
      memAck   <= 1'h0;
      // data is only good with the strobe: keep it moving so a late sample shows up
      memRdata <= ~memRdata;
      waitCnt  <= (memReq && !memAck) ? waitCnt + 4'h1 : 4'h0;
    end
  end
endmodule // walk_memory

/* verif/translation_lookaside_unit_chk.sv */
`include "tlu_defs.vh"
module translation_lookaside_unit_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        irq_ff,
  input wire logic        iAck_ff,
  input wire logic [31:0] iPa_ff,
  input wire logic [1:0]  fetchFaultVariants_ff,
  input wire logic        dReq,
  input wire logic        dWrite,
  input wire logic        dAck_ff,
  input wire logic [31:0] dPa_ff,
  input wire logic [2:0]  dataFaultVariants_ff,
  input wire logic        memReq_ff,
  input wire logic [31:0] memAddr_ff,
  input wire logic        memAck
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [19:0] base_ff;
  logic        cfgOk;
  assign cfgOk = regWdata[2:0] inside {`TLU_SZ_8K, `TLU_SZ_64K, `TLU_SZ_4M, `TLU_SZ_256M};
  // illegal size codes leave the stored table base untouched
  always @(posedge clk)
    if (rst)
      base_ff <= 20'h0;
    else if (regWr && regAddr == `TLU_OFS_TCFG && cfgOk)
      base_ff <= regWdata[31:12];
  AST_TCFG_BASE: assert property ($rose(memReq_ff) |-> memAddr_ff[31:12] == base_ff
    && memAddr_ff[2:0] == 3'h0) else $error("walk address not on table base");
  AST_MEM_HOLD: assert property (memReq_ff && !memAck |=> memReq_ff && $stable(memAddr_ff))
    else $error("walk request dropped early");
  AST_WALK_DONE: assert property (memReq_ff && memAck |-> ##[1:3] (iAck_ff || dAck_ff))
    else $error("no answer after walk");
  AST_DHIT: assert property (dAck_ff |-> $past(dReq) && $past(dReq, 2))
    else $error("data answer without request");
  AST_DFLT_PA: assert property (dAck_ff && dataFaultVariants_ff != 3'h0 |-> dPa_ff == 32'h0)
    else $error("faulting data answer carries address");
  AST_PROT_STORE: assert property (dAck_ff && dataFaultVariants_ff[1] |-> dWrite)
    else $error("protection fault on load");
  AST_IMULTI: assert property (fetchFaultVariants_ff[1] |-> iAck_ff && iPa_ff == 32'h0)
    else $error("fetch multi hit not clean");
  AST_IRQ_MASK: assert property (regWr && regAddr == `TLU_OFS_MASK && regWdata[3:0] == 4'h0
    |=> ##1 !irq_ff) else $error("irq with all masked");
endmodule // translation_lookaside_unit_chk
bind translation_lookaside_unit translation_lookaside_unit_chk chk_u (.clk, .rst, .regAddr,
  .regWdata, .regWr, .irq_ff, .iAck_ff, .iPa_ff, .fetchFaultVariants_ff, .dReq, .dWrite,
  .dAck_ff, .dPa_ff, .dataFaultVariants_ff, .memReq_ff, .memAddr_ff, .memAck);

/* verif/tb_top.sv */
`include "tlu_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  regAddr = 8'h0;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'h0;
  logic        regRd = 1'h0;
  logic        iReq = 1'h0;
  logic        dReq = 1'h0;
  logic        dWrite = 1'h0;
  logic [31:0] reqVa = 32'h0;
  logic [1:0]  reqCs = 2'h0;
  logic        reqReal = 1'h0;
  logic [3:0]  memDelay = 4'h0;
  wire  [31:0] regRdata_ff, iPa_ff, dPa_ff, memAddr_ff;
  wire  [63:0] memRdata;
  wire  [1:0]  fetchFaultVariants_ff;
  wire  [2:0]  dataFaultVariants_ff;
  wire         irq_ff, iAck_ff, dAck_ff, memReq_ff, memAck;
  int          mismatches = 0, total_checks = 0, walks = 0, lat;
  logic [31:0] walkAddr;
  logic [2:0]  szTab [4] = '{`TLU_SZ_8K, `TLU_SZ_64K, `TLU_SZ_4M, `TLU_SZ_256M};
  translation_lookaside_unit dut_u (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata_ff, .irq_ff, .iReq, .iVa(reqVa), .iCtxSel(reqCs), .iReal(reqReal), .iAck_ff,
    .iPa_ff, .fetchFaultVariants_ff, .dReq, .dVa(reqVa), .dCtxSel(reqCs), .dReal(reqReal),
    .dWrite, .dAck_ff, .dPa_ff, .dataFaultVariants_ff, .memReq_ff, .memAddr_ff, .memAck,
    .memRdata);
  walk_memory mem_u (.clk, .rst, .memReq(memReq_ff), .memAddr(memAddr_ff), .delay(memDelay),
    .memAck, .memRdata);
  initial forever #5 clk = ~clk;
  always @(posedge clk)
    if (memReq_ff === 1'h1 && memAck === 1'h1) begin
      walks <= walks + 1;
      walkAddr <= memAddr_ff;
    end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    #1;
    chk(regRdata_ff, e);
  endtask
  task automatic ld(input logic [63:0] e, input logic fb);
    wr(`TLU_OFS_DINHI, e[63:32]);
    wr(`TLU_OFS_DINLO, e[31:0]);
    wr(`TLU_OFS_LOAD, {31'h0, fb});
  endtask
  function automatic logic [63:0] tte(input logic r, input logic [2:0] sz,
      input logic [7:0] cx, input logic [31:0] va, input logic [18:0] pp, input logic w);
    return {1'h1, r, sz, cx, va[31:13], pp, 11'h0, w, 1'h0};
  endfunction
  function automatic logic [31:0] pa(input logic [63:0] e, input logic [31:0] va);
    logic [18:0] m;
    case (e[61:59])
      `TLU_SZ_8K:  m = `TLU_MSK_8K;
      `TLU_SZ_64K: m = `TLU_MSK_64K;
      `TLU_SZ_4M:  m = `TLU_MSK_4M;
      default:     m = `TLU_MSK_256M;
    endcase
    return {(e[31:13] & m) | (va[31:13] & ~m), va[12:0]};
  endfunction
  // same va/context/real lines feed both ports; only the request strobe differs
  task automatic tr(input logic f, input logic [31:0] va, input logic [1:0] cs,
      input logic r, input logic w, input logic [31:0] ePa, input logic [2:0] eF);
    int n;
    @(posedge clk);
    reqVa <= va;
    reqCs <= cs;
    reqReal <= r;
    dWrite <= w;
    if (f)
      iReq <= 1'h1;
    else
      dReq <= 1'h1;
    for (n = 1; n < 60; n++) begin
      @(posedge clk);
      #1;
      if ((f ? iAck_ff : dAck_ff) === 1'h1)
        break;
    end
    // drop in the ack cycle: a request still high at the next edge is taken again
    iReq <= 1'h0;
    dReq <= 1'h0;
    lat = n;
    chk({31'h0, f ? iAck_ff : dAck_ff}, 32'h1);
    chk(f ? iPa_ff : dPa_ff, ePa);
    chk(f ? {30'h0, fetchFaultVariants_ff} : {29'h0, dataFaultVariants_ff}, {29'h0, eF});
  endtask
  task automatic t_regs;
    rd(`TLU_OFS_PCTX0, 32'h0);
    rd(`TLU_OFS_TCFG, `TLU_TCFG_RST);
    rd(8'h3c, 32'h0);
    for (int i = 1; i < 4; i++) begin
      wr(8'(i * 4), 32'h11 * i);
      rd(8'(i * 4), 32'h11 * i);
    end
    $display("t_regs done");
  endtask
  task automatic t_sizes;
    logic [63:0] e;
    for (int i = 0; i < 4; i++) begin
      e = tte(1'h0, szTab[i], 8'h33, 32'h9abc_def0, 19'h5a5a5, 1'h1);
      ld(e, 1'h0);
      tr(1'h0, 32'h9abc_def0, 2'h3, 1'h0, 1'h1, pa(e, 32'h9abc_def0), 3'h0);
      chk(lat, 2);
      wr(`TLU_OFS_DEMAP, 32'h2);
    end
    $display("t_sizes done");
  endtask
  task automatic t_walk;
    logic [63:0] e;
    e = tte(1'h0, `TLU_SZ_8K, 8'h0, 32'h0040_6000, 19'h12345, 1'h0);
    mem_u.tbl[e[40:32]] = e;
    wr(`TLU_OFS_TCFG, 32'h0008_0000);
    memDelay <= 4'h3;
    tr(1'h0, 32'h0040_6abc, 2'h0, 1'h0, 1'h0, pa(e, 32'h0040_6abc), 3'h0);
    chk(walks, 1);
    chk(walkAddr, {20'h00080, 9'h3, 3'h0});
    tr(1'h0, 32'h0040_6abc, 2'h0, 1'h0, 1'h0, pa(e, 32'h0040_6abc), 3'h0);
    chk(lat, 2);
    tr(1'h0, 32'h0040_6abc, 2'h0, 1'h0, 1'h1, 32'h0, 3'h2);
    tr(1'h0, 32'h0150_0000, 2'h0, 1'h0, 1'h0, 32'h0, 3'h1);
    tr(1'h1, 32'h0150_0000, 2'h0, 1'h0, 1'h0, 32'h0, 3'h1);
    rd(`TLU_OFS_STAT, 32'h8);
    wr(`TLU_OFS_STAT, 32'h8);
    rd(`TLU_OFS_STAT, 32'h0);
    $display("t_walk done");
  endtask
  task automatic t_trap;
    wr(`TLU_OFS_MASK, 32'h4);
    wr(`TLU_OFS_TCFG, 32'h00ff_f002);
    rd(`TLU_OFS_TCFG, 32'h0008_0000);
    rd(`TLU_OFS_STAT, 32'h4);
    chk(irq_ff, 1'h1);
    wr(`TLU_OFS_STAT, 32'h4);
    ld(tte(1'h0, 3'h2, 8'h0, 32'h0260_0000, 19'h1, 1'h1), 1'h0);
    rd(`TLU_OFS_STAT, 32'h4);
    wr(`TLU_OFS_STAT, 32'h4);
    wr(`TLU_OFS_MASK, 32'h0);
    tr(1'h0, 32'h0260_0000, 2'h0, 1'h0, 1'h0, 32'h0, 3'h1);
    rd(`TLU_OFS_STAT, 32'h8);
    chk(irq_ff, 1'h0);
    $display("t_trap done");
  endtask
  task automatic t_real;
    logic [63:0] e;
    e = tte(1'h0, `TLU_SZ_8K, 8'h0, 32'h0310_0000, 19'h8, 1'h1);
    ld(tte(1'h1, `TLU_SZ_8K, 8'h0, 32'h0300_0000, 19'h7, 1'h1), 1'h0);
    ld(e, 1'h0);
    wr(`TLU_OFS_DEMAP, 32'h1);
    tr(1'h0, 32'h0300_0000, 2'h0, 1'h1, 1'h0, 32'h0, 3'h1);
    tr(1'h0, 32'h0310_0000, 2'h0, 1'h0, 1'h0, pa(e, 32'h0310_0000), 3'h0);
    chk(lat, 2);
    $display("t_real done");
  endtask
  task automatic t_auto;
    logic [63:0] e;
    wr(`TLU_OFS_STAT, 32'hf);
    e = tte(1'h0, `TLU_SZ_8K, 8'h0, 32'h0400_2000, 19'h200, 1'h0);
    ld(tte(1'h0, `TLU_SZ_64K, 8'h0, 32'h0400_0000, 19'h100, 1'h0), 1'h1);
    ld(e, 1'h1);
    tr(1'h1, 32'h0400_0000, 2'h0, 1'h0, 1'h0, 32'h0, 3'h1);
    tr(1'h1, 32'h0400_2000, 2'h0, 1'h0, 1'h0, pa(e, 32'h0400_2000), 3'h0);
    ld(tte(1'h0, `TLU_SZ_8K, 8'h0, 32'h0500_0000, 19'h300, 1'h0), 1'h1);
    ld(tte(1'h0, `TLU_SZ_64K, 8'h0, 32'h0500_0000, 19'h400, 1'h0), 1'h1);
    tr(1'h1, 32'h0500_0000, 2'h0, 1'h0, 1'h0, 32'h0, 3'h2);
    rd(`TLU_OFS_STAT, 32'h9);
    $display("t_auto done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    t_regs;
    t_sizes;
    t_walk;
    t_trap;
    t_real;
    t_auto;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out;
  end
endmodule // tb_top
